// file: pkg/spl_cfg.svh
// constants for the serial-in parallel-out shift latch
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH
`define SPL_WIDTH 8
`define SPL_MSB 7
`define SPL_STAGE0 0
`define SPL_STAGE6 6
`define SPL_RESET_WORD 8'h00
`define SPL_BUF_DEPTH 2
`endif

// file: pkg/spl_pkg.sv
// types for the serial-in parallel-out shift latch
`include "spl_cfg.svh"
package spl_pkg;
    typedef logic [`SPL_MSB:0] spl_word_t;
    typedef logic [1:0] spl_count_t;
endpackage

// file: src/spl_buf.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "spl_cfg.svh"
module spl_buf (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire spl_pkg::spl_word_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output spl_pkg::spl_word_t out_data
);
    spl_pkg::spl_word_t mem_reg [0:`SPL_BUF_DEPTH-1];
    spl_pkg::spl_word_t mem_next [0:`SPL_BUF_DEPTH-1];
    spl_pkg::spl_count_t count_reg;
    spl_pkg::spl_count_t count_next;
    logic push;
    logic pop;

    // entry 0 is the head; a pop shifts entry 1 down
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        mem_next[0] = mem_reg[0];
        mem_next[1] = mem_reg[1];
        count_next = count_reg;
        if (pop) begin
            mem_next[0] = mem_reg[1];
            count_next = count_reg - 2'h1;
        end
        if (push) begin
            mem_next[count_next[0]] = in_data;
            count_next = count_next + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_reg[0] <= `SPL_RESET_WORD;
            mem_reg[1] <= `SPL_RESET_WORD;
            count_reg <= 2'h0;
        end else begin
            mem_reg[0] <= mem_next[0];
            mem_reg[1] <= mem_next[1];
            count_reg <= count_next;
        end
    end

    // full refuses a push even if a pop happens in the same cycle: keeps ready a flop
    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[0];
endmodule

// file: src/spl_top.sv
// serial-in shift register with storage register and enabled parallel outputs
`timescale 1ns/1ps
`include "spl_cfg.svh"
module spl_top (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic SHIFT_CLOCK,
    input wire logic LATCH_CLOCK,
    input wire logic MASTER_CLEAR_N,
    input wire logic SERIAL_IN,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic Q_READY,
    output logic LATCH_READY,
    output logic Q_VALID,
    output logic [`SPL_MSB:0] Q_OUT,
    output logic [`SPL_MSB:0] Q_OE,
    output logic CASCADE_OUT
);
    // ****************************************
    // input edge detection
    // ****************************************
    logic shift_prev_reg;
    logic shift_prev_next;
    logic latch_prev_reg;
    logic latch_prev_next;
    logic shift_rise;
    logic latch_rise;

    // the previous-level flops only follow the pins
    always_comb begin
        shift_prev_next = SHIFT_CLOCK;
        latch_prev_next = LATCH_CLOCK;
    end

    // pins are synchronous to CLK, so a plain previous-value flop finds the edges;
    // reset value matches the idle low pins, so no false edge follows reset
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            shift_prev_reg <= 1'b0;
            latch_prev_reg <= 1'b0;
        end else begin
            shift_prev_reg <= shift_prev_next;
            latch_prev_reg <= latch_prev_next;
        end
    end

    assign shift_rise = SHIFT_CLOCK && !shift_prev_reg;
    assign latch_rise = LATCH_CLOCK && !latch_prev_reg;

    // ****************************************
    // shift stages
    // ****************************************
    spl_pkg::spl_word_t stage_bits_reg;
    spl_pkg::spl_word_t stage_bits_next;

    // limitation: clear is seen at the next CLK edge, since all pins are synchronous
    // clear wins over a shift in the same cycle
    always_comb begin
        stage_bits_next = stage_bits_reg;
        if (!MASTER_CLEAR_N) begin
            stage_bits_next = `SPL_RESET_WORD;
        end else if (shift_rise) begin
            stage_bits_next = {stage_bits_reg[`SPL_MSB-1:0], SERIAL_IN};
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            stage_bits_reg <= `SPL_RESET_WORD;
        end else begin
            stage_bits_reg <= stage_bits_next;
        end
    end

    // last stage straight out, never gated by the output enable
    assign CASCADE_OUT = stage_bits_reg[`SPL_MSB];

    // ****************************************
    // capture buffer
    // ****************************************
    spl_pkg::spl_word_t capture_word;
    logic buf_in_ready;
    logic buf_out_valid;
    spl_pkg::spl_word_t buf_out_data;

    // capture the pre-shift stages; a pending clear makes the word zero
    always_comb begin
        capture_word = MASTER_CLEAR_N ? stage_bits_reg : `SPL_RESET_WORD;
    end

    // a latch edge while the buffer is full is dropped; LATCH_READY warns the source
    spl_buf u_buf (
        .clk(CLK),
        .resetn(RESETN),
        .in_valid(latch_rise),
        .in_ready(buf_in_ready),
        .in_data(capture_word),
        .out_valid(buf_out_valid),
        .out_ready(Q_READY),
        .out_data(buf_out_data)
    );

    // ****************************************
    // storage register and output drivers
    // ****************************************
    spl_pkg::spl_word_t storage_reg;
    spl_pkg::spl_word_t storage_next;
    logic [`SPL_MSB:0] oe_reg;
    logic [`SPL_MSB:0] oe_next;
    logic valid_reg;
    logic valid_next;
    logic ready_reg;
    logic ready_next;

    // storage moves only on a delivered word, so master clear cannot reach it
    always_comb begin
        storage_next = storage_reg;
        valid_next = 1'b0;
        if (buf_out_valid && Q_READY) begin
            storage_next = buf_out_data;
            valid_next = 1'b1;
        end
        ready_next = buf_in_ready;
    end

    // one enable per output pin, so each pad driver gets its own flop
    generate
        for (genvar pin = 0; pin < `SPL_WIDTH; pin++) begin : g_oe
            assign oe_next[pin] = !OUTPUT_ENABLE_N;
        end
    endgenerate

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            storage_reg <= `SPL_RESET_WORD;
            oe_reg <= 8'h00;
            valid_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            storage_reg <= storage_next;
            oe_reg <= oe_next;
            valid_reg <= valid_next;
            ready_reg <= ready_next;
        end
    end

    assign Q_OUT = storage_reg;
    assign Q_OE = oe_reg;
    assign Q_VALID = valid_reg;
    assign LATCH_READY = ready_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence s_shift_clean;
        shift_rise && MASTER_CLEAR_N;
    endsequence

    sequence s_latch_alone;
        latch_rise && !shift_rise && MASTER_CLEAR_N && buf_in_ready;
    endsequence

    // a word entering an empty buffer and taken on the next edge shows two edges later
    sequence s_taken_next;
        !buf_out_valid ##1 Q_READY;
    endsequence

    a_shift_moves_up: assert property (s_shift_clean |=>
        stage_bits_reg[`SPL_MSB:1] == $past(stage_bits_reg[`SPL_MSB-1:0]))
        else $error("stages did not move up");

    a_serial_in_load: assert property (s_shift_clean |=>
        stage_bits_reg[`SPL_STAGE0] == $past(SERIAL_IN)
        && CASCADE_OUT == $past(stage_bits_reg[`SPL_STAGE6]))
        else $error("serial load or cascade wrong");

    a_clear_holds: assert property (!MASTER_CLEAR_N |=>
        stage_bits_reg == 8'h00 && !CASCADE_OUT)
        else $error("clear did not empty stages");

    a_storage_kept: assert property (!(buf_out_valid && Q_READY) |=>
        $stable(Q_OUT))
        else $error("storage changed without delivery");

    a_latch_zero: assert property (
        (latch_rise && !MASTER_CLEAR_N && buf_in_ready) ##0 s_taken_next
        |=> Q_OUT == 8'h00 && Q_VALID)
        else $error("clear latch did not load zeros");

    a_oe_drive: assert property (!OUTPUT_ENABLE_N |=> Q_OE == 8'hFF)
        else $error("outputs not enabled");

    a_oe_release: assert property (OUTPUT_ENABLE_N |=> Q_OE == 8'h00)
        else $error("outputs not released");

    a_latch_alone: assert property (
        s_latch_alone ##0 s_taken_next
        |=> $past(CASCADE_OUT) == $past(CASCADE_OUT, 2)
        && Q_OUT == $past(stage_bits_reg, 2) && Q_VALID)
        else $error("lone latch misbehaved");

    a_tied_capture: assert property (
        s_shift_clean ##0 (latch_rise && buf_in_ready) ##0 s_taken_next
        |=> Q_OUT == $past(stage_bits_reg, 2))
        else $error("storage not one pulse behind");
endmodule

// file: tb/spl_ctrl.sv
// controller model driving the shift latch pins
`timescale 1ns/1ps
module spl_ctrl (
    input wire logic clk,
    output logic sh_clk,
    output logic la_clk,
    output logic clear_n,
    output logic sdata,
    output logic oe_n
);
    // idle clocks low, clear released, outputs enabled from time zero
    initial begin
        sh_clk = 1'b0;
        la_clk = 1'b0;
        clear_n = 1'b1;
        sdata = 1'b0;
        oe_n = 1'b0;
    end
    // high one cycle, low one cycle, so each rise is seen alone
    task pulse(input logic s, input logic l, input logic d);
        @(posedge clk);
        #1;
        sh_clk = s;
        la_clk = l;
        sdata = d;
        @(posedge clk);
        #1;
        sh_clk = 1'b0;
        la_clk = 1'b0;
        sdata = ~d; // stale data must not look valid
    endtask
    // levels change only just after an edge
    task set_pins(input logic c, input logic e);
        @(posedge clk);
        #1;
        clear_n = c;
        oe_n = e;
    endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the shift latch
`timescale 1ns/1ps
module testbench;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic q_ready = 1'b0;
    logic sh, la, mc_n, sd, oe_n, lrdy, qv, cas;
    logic [7:0] q_out, q_oe, sreg, last_q;
    logic [7:0] expq[$];
    integer num_errors = 0;
    integer total_checks = 0;
    integer seed = 24056;
    integer q_mode = 1;
    integer i, n;
    always #10 CLK = ~CLK;
    spl_ctrl u_ctl (.clk(CLK), .sh_clk(sh), .la_clk(la), .clear_n(mc_n), .sdata(sd),
        .oe_n(oe_n));
    spl_top u_dut (.CLK(CLK), .RESETN(RESETN), .SHIFT_CLOCK(sh), .LATCH_CLOCK(la),
        .MASTER_CLEAR_N(mc_n), .SERIAL_IN(sd), .OUTPUT_ENABLE_N(oe_n), .Q_READY(q_ready),
        .LATCH_READY(lrdy), .Q_VALID(qv), .Q_OUT(q_out), .Q_OE(q_oe), .CASCADE_OUT(cas));
    // ********************
    // checking helpers
    // ********************
    task chk(input string name, input logic [7:0] e, input logic [7:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", name, e, g);
            num_errors = num_errors + 1;
        end
    endtask
    task wrap_up;
        if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // receiver: looks at each delivered word at the falling edge, where outputs have settled
    always @(negedge CLK) begin
        if (qv === 1'b1) begin
            if (expq.size() == 0) chk("extra_word", 8'h00, 8'h01);
            else chk("q_out", expq.pop_front(), q_out);
        end
    end
    // receiver stalls at random, or holds ready at the level that q_mode asks for
    always @(posedge CLK) begin
        q_ready <= #1 (q_mode == 2) ? ($random(seed) % 4 != 0) : q_mode[0];
    end
    // model first, then pins; captured word is the pre-shift one, or zero under clear
    task op(input logic s, input logic l, input logic k);
        integer r;
        r = $random(seed);
        if (l && k) expq.push_back(mc_n ? sreg : 8'h00);
        if (s && mc_n) sreg = {sreg[6:0], r[0]};
        u_ctl.pulse(s, l, r[0]);
        @(posedge CLK);
        #1;
        chk("cascade", {7'h00, sreg[7]}, {7'h00, cas});
    endtask
    // bounded wait for the buffer to empty
    task drain;
        for (n = 0; n < 200 && expq.size() != 0; n++) @(posedge CLK);
        #1;
        chk("pending", 8'h00, 8'(expq.size()));
    endtask
    initial begin
        #1000000;
        num_errors = num_errors + 1;
        wrap_up;
    end
    // main sequence
    initial begin
        sreg = 8'h00;
        repeat (20) @(posedge CLK);
        #1;
        RESETN = 1'b1;
        repeat (2) @(posedge CLK);
        #1;
        chk("q_oe", 8'hFF, q_oe);
        q_mode = 2;
        for (i = 0; i < 4; i++) begin
            repeat (8) op(1'b1, 1'b0, 1'b1);
            op(1'b0, 1'b1, 1'b1);
        end
        repeat (12) op(1'b1, 1'b1, 1'b1);
        drain;
        last_q = q_out;
        sreg = 8'h00;
        u_ctl.set_pins(1'b0, 1'b0);
        op(1'b1, 1'b0, 1'b1);
        chk("q_hold", last_q, q_out);
        op(1'b0, 1'b1, 1'b1);
        drain;
        chk("q_clear", 8'h00, q_out);
        u_ctl.set_pins(1'b1, 1'b1);
        repeat (2) @(posedge CLK);
        #1;
        chk("q_oe_off", 8'h00, q_oe);
        op(1'b1, 1'b0, 1'b1);
        u_ctl.set_pins(1'b1, 1'b0);
        // receiver stalled: third word finds the buffer full and is dropped
        q_mode = 0;
        for (i = 0; i < 3; i++) begin
            op(1'b1, 1'b0, 1'b1);
            op(1'b0, 1'b1, i < 2);
        end
        chk("latch_ready", 8'h00, {7'h00, lrdy});
        q_mode = 1;
        drain;
        wrap_up;
    end
endmodule
